// [inc/sleep_pkg.sv]
// constants shared by the sleep-mode controller files
package sleep_pkg;
  // register port
  localparam int REG_ADDR_W = 2;
  localparam logic [REG_ADDR_W-1:0] OFS_CTRL = 2'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 2'h1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // control register fields
  localparam int BIT_SEL_HI = 7;
  localparam int BIT_ARM = 6;
  localparam int BIT_SEL_MID = 5;
  localparam int BIT_SEL_LO = 4;
  // status register fields
  localparam int BIT_ST_ASLEEP = 0;
  localparam int BIT_ST_UNDEF = 1;
  localparam int BIT_ST_MODE_LO = 2;
  // sleep mode codes
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_CONV_NR = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE = 3'h3;
  localparam logic [2:0] MODE_RSVD_A = 3'h4;
  localparam logic [2:0] MODE_RSVD_B = 3'h5;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;
  // timing in clk cycles
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] HOLD_CYC = 16'h0004;
  localparam logic [CNT_W-1:0] STANDBY_WAKE_CYC = 16'h0006;
  localparam logic [CNT_W-1:0] MIN_STARTUP_CYC = 16'h0001;
  // wake source vector
  localparam int WAKE_W = 9;
  localparam int W_LVL0 = 0;
  localparam int W_LVL1 = 1;
  localparam int W_LINE2 = 2;
  localparam int W_TWI = 3;
  localparam int W_T2OVF = 4;
  localparam int W_T2CMP = 5;
  localparam int W_CONV = 6;
  localparam int W_SPM = 7;
  localparam int W_OTHER = 8;
endpackage

// [inc/wake_if.sv]
// wake qualification signals between controller and qualifier
`timescale 1ns/1ns
interface wake_if;
  import sleep_pkg::*;
  logic [2:0] mode;
  logic [WAKE_W-1:0] src;
  logic t2Async;
  logic t2OvfIe;
  logic t2CmpIe;
  logic globalIe;
  logic wake;
  modport ctrl (output mode, output src, output t2Async, output t2OvfIe, output t2CmpIe,
                output globalIe, input wake);
  modport qual (input mode, input src, input t2Async, input t2OvfIe, input t2CmpIe,
                input globalIe, output wake);
endinterface

// [hdl/sync2.sv]
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // sync2

// [hdl/wake_qualifier.sv]
// per-mode wake source filter
`timescale 1ns/1ns
module wake_qualifier
  import sleep_pkg::*;
(
  wake_if.qual w
);
  logic t2Wake;
  logic asyncWake;

  // in power-save and ext standby, timer 2 only wakes when on its own clock and enabled
  assign t2Wake = w.t2Async && w.globalIe &&
                  ((w.src[W_T2OVF] && w.t2OvfIe) || (w.src[W_T2CMP] && w.t2CmpIe)); // see (R20)
  assign asyncWake = w.src[W_TWI] || w.src[W_LVL0] || w.src[W_LVL1] || w.src[W_LINE2];

  always_comb begin
    case (w.mode)
      MODE_IDLE: w.wake = |w.src; // see (R11)
      MODE_CONV_NR: w.wake = asyncWake || w.src[W_CONV] || w.src[W_SPM] ||
                             w.src[W_T2OVF] || w.src[W_T2CMP]; // see (R14)
      MODE_PWR_DOWN, MODE_STANDBY: w.wake = asyncWake; // see (R16)
      MODE_PWR_SAVE, MODE_EXT_STANDBY: w.wake = asyncWake || t2Wake; // see (R19)
      default: w.wake = 1'b0;
    endcase
  end
endmodule // wake_qualifier

// [hdl/sleep_mode_controller.sv]
// sleep-mode controller: control register, clock gating and wake sequencing
`timescale 1ns/1ns

// How it works
// (R1) halt sleeps only with the arm bit set; mode comes from the select field
// (R2) select bits sit at 7,5,4 high to low; arm bit at 6
// (R3) codes: 0 idle,1 conv,2 pdown,3 psave,4-5 reserved,6 standby,7 ext standby
// (R4) standby modes only offered with a crystal or resonator clock
// (R5) interrupt wake: halt four cycles past start-up, then handler, then resume
// (R6) wake leaves register file and SRAM untouched
// (R7) reset while asleep wakes and restarts from the reset vector
// (R8) all eight control bits read/write, zero after reset
// (R9) software arms just before halt and disarms after wake
// (R10) idle stops only CPU and flash clocks
// (R11) idle wakes on any enabled interrupt
// (R12) idle or converter mode with converter enabled starts a conversion
// (R13) converter mode stops I/O, CPU and flash clocks
// (R14) converter mode wakes only on its listed sources
// (R15) power-down stops oscillator and all generated clocks
// (R16) power-down wakes only on resets, address match, line levels, line 2
// (R17) a level wake source must hold its level long enough
// (R18) power-down wake waits the fuse-defined start-up time
// (R19) power-save is power-down plus timer 2 on its async clock
// (R20) timer 2 wakes power-save only with its enable and global enable set
// (R21) software picks power-down when timer 2 is not asynchronous
// (R22) software may disable the comparator to save idle power
// (R23) standby modes keep the oscillator and wake in six cycles
// (R24) power-save wake without async timer flags async timer undefined
// (R25) halt with arm bit clear is a no-operation
module sleep_mode_controller
  import sleep_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // cpu core
  input wire logic haltInstr,
  output logic haltNop,
  output logic irqResume,
  output logic resetVector,
  output logic asleep,
  // clock domain enables
  output logic cpuClkEn,
  output logic flashClkEn,
  output logic ioClkEn,
  output logic convClkEn,
  output logic asyncClkEn,
  output logic mainOscEn,
  output logic asyncTimerUndef,
  // converter
  input wire logic convEnabled,
  output logic convStart,
  // configuration levels
  input wire logic extCrystalSel,
  input wire logic [CNT_W-1:0] startupCycles,
  input wire logic timer2AsyncSel,
  input wire logic timer2OvfIe,
  input wire logic timer2CmpIe,
  input wire logic globalIe,
  // wake sources from pins
  input wire logic extIrqLine0,
  input wire logic extIrqLine1,
  input wire logic extIrqLine2,
  // wake sources from on-chip logic
  input wire logic twiAddrMatch,
  input wire logic timer2Ovf,
  input wire logic timer2Cmp,
  input wire logic convDone,
  input wire logic spmReady,
  input wire logic otherIrq,
  input wire logic resetWake
);
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HOLD
  } state_e;

  state_e state_q;
  logic [7:0] ctrl_q;
  logic [2:0] mode_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] pinSync;
  logic [2:0] selMode;
  logic modeOffered;
  logic enterSleep;
  logic ctrlHit;
  logic statusHit;
  logic [CNT_W-1:0] startupLen;
  logic [7:0] statusVal;
  wake_if wk ();

  // pin levels pass two flops before use
  sync2 #(
    .W(3)
  ) u_pin_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({extIrqLine2, extIrqLine1, extIrqLine0}),
    .syncOut(pinSync)
  );

  assign wk.mode = mode_q;
  assign wk.src[W_LVL0] = pinSync[0];
  assign wk.src[W_LVL1] = pinSync[1];
  assign wk.src[W_LINE2] = pinSync[2];
  assign wk.src[W_TWI] = twiAddrMatch;
  assign wk.src[W_T2OVF] = timer2Ovf;
  assign wk.src[W_T2CMP] = timer2Cmp;
  assign wk.src[W_CONV] = convDone;
  assign wk.src[W_SPM] = spmReady;
  assign wk.src[W_OTHER] = otherIrq;
  assign wk.t2Async = timer2AsyncSel;
  assign wk.t2OvfIe = timer2OvfIe;
  assign wk.t2CmpIe = timer2CmpIe;
  assign wk.globalIe = globalIe;

  wake_qualifier u_wake_qual (
    .w(wk.qual)
  );

  // field decode
  assign selMode = {ctrl_q[BIT_SEL_HI], ctrl_q[BIT_SEL_MID], ctrl_q[BIT_SEL_LO]}; // see (R2)

  always_comb begin
    case (selMode)
      MODE_IDLE, MODE_CONV_NR, MODE_PWR_DOWN, MODE_PWR_SAVE: modeOffered = 1'b1; // see (R3)
      MODE_STANDBY, MODE_EXT_STANDBY: modeOffered = extCrystalSel; // see (R4)
      default: modeOffered = 1'b0;
    endcase
  end

  assign enterSleep = state_q == ST_RUN && haltInstr && ctrl_q[BIT_ARM] && modeOffered; // see (R1)

  // start-up delay per mode, never below one cycle
  always_comb begin
    case (mode_q)
      MODE_PWR_DOWN, MODE_PWR_SAVE: // see (R18)
        startupLen = (startupCycles < MIN_STARTUP_CYC) ? MIN_STARTUP_CYC : startupCycles;
      MODE_STANDBY, MODE_EXT_STANDBY: startupLen = STANDBY_WAKE_CYC; // see (R23)
      default: startupLen = MIN_STARTUP_CYC;
    endcase
  end

  // register decode
  assign ctrlHit = (regAddr == OFS_CTRL);
  assign statusHit = (regAddr == OFS_STATUS);

  always_comb begin
    statusVal = STATUS_RESET;
    statusVal[BIT_ST_ASLEEP] = asleep;
    statusVal[BIT_ST_UNDEF] = asyncTimerUndef;
    statusVal[BIT_ST_MODE_LO +: 3] = mode_q;
  end

  // control register: all bits read/write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= CTRL_RESET; // see (R8)
    end else if (regWr && ctrlHit) begin
      ctrl_q <= regWrData; // see (R8)
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= UNMAPPED_READ;
    end else if (regRd) begin
      if (ctrlHit) begin
        regRdData <= ctrl_q;
      end else if (statusHit) begin
        regRdData <= statusVal;
      end else begin
        regRdData <= UNMAPPED_READ;
      end
    end else begin
      regRdData <= UNMAPPED_READ;
    end
  end

  // halt without arm, or with a mode not on offer, does nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      haltNop <= 1'b0;
    end else begin
      haltNop <= (state_q == ST_RUN) && haltInstr && !enterSleep; // see (R25)
    end
  end

  // sequencer; only control flow changes, no memory content is touched
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_RUN;
      mode_q <= MODE_IDLE;
      cnt_q <= '0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (enterSleep) begin
            state_q <= ST_SLEEP;
            mode_q <= selMode; // see (R1)
          end
        end
        ST_SLEEP: begin
          if (resetWake) begin
            state_q <= ST_RUN; // see (R7)
          end else if (wk.wake) begin
            state_q <= ST_STARTUP;
            cnt_q <= startupLen;
          end
        end
        ST_STARTUP: begin
          if (resetWake) begin
            state_q <= ST_RUN; // see (R7)
          end else if (cnt_q <= MIN_STARTUP_CYC) begin
            state_q <= ST_HOLD;
            cnt_q <= HOLD_CYC; // see (R5)
          end else begin
            cnt_q <= cnt_q - MIN_STARTUP_CYC;
          end
        end
        ST_HOLD: begin
          if (resetWake) begin
            state_q <= ST_RUN; // see (R7)
          end else if (cnt_q <= MIN_STARTUP_CYC) begin
            state_q <= ST_RUN; // see (R6)
          end else begin
            cnt_q <= cnt_q - MIN_STARTUP_CYC;
          end
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // wake outcome pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqResume <= 1'b0;
      resetVector <= 1'b0;
    end else begin
      irqResume <= (state_q == ST_HOLD) && !resetWake && (cnt_q <= MIN_STARTUP_CYC); // see (R5)
      resetVector <= (state_q != ST_RUN) && resetWake; // see (R7)
    end
  end

  // clock domain gating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cpuClkEn <= 1'b1;
      flashClkEn <= 1'b1;
      ioClkEn <= 1'b1;
      convClkEn <= 1'b1;
      asyncClkEn <= 1'b1;
      mainOscEn <= 1'b1;
      asleep <= 1'b0;
    end else if (enterSleep) begin
      asleep <= 1'b1;
      cpuClkEn <= 1'b0; // see (R10)
      flashClkEn <= 1'b0; // see (R10)
      case (selMode)
        MODE_IDLE: begin
          ioClkEn <= 1'b1; // see (R10)
          convClkEn <= 1'b1;
          asyncClkEn <= 1'b1;
          mainOscEn <= 1'b1;
        end
        MODE_CONV_NR: begin
          ioClkEn <= 1'b0; // see (R13)
          convClkEn <= 1'b1;
          asyncClkEn <= 1'b1;
          mainOscEn <= 1'b1;
        end
        MODE_PWR_SAVE, MODE_EXT_STANDBY: begin
          ioClkEn <= 1'b0;
          convClkEn <= 1'b0;
          asyncClkEn <= timer2AsyncSel; // see (R19)
          mainOscEn <= (selMode == MODE_EXT_STANDBY); // see (R23)
        end
        default: begin
          ioClkEn <= 1'b0; // see (R15)
          convClkEn <= 1'b0;
          asyncClkEn <= 1'b0;
          mainOscEn <= (selMode == MODE_STANDBY); // see (R23)
        end
      endcase
    end else if ((state_q == ST_SLEEP) && (wk.wake || resetWake)) begin
      mainOscEn <= 1'b1;
      if (resetWake) begin
        cpuClkEn <= 1'b1;
        flashClkEn <= 1'b1;
        ioClkEn <= 1'b1;
        convClkEn <= 1'b1;
        asyncClkEn <= 1'b1;
        asleep <= 1'b0;
      end
    end else if ((state_q == ST_STARTUP) && (resetWake || (cnt_q <= MIN_STARTUP_CYC))) begin
      flashClkEn <= 1'b1;
      ioClkEn <= 1'b1;
      convClkEn <= 1'b1;
      asyncClkEn <= 1'b1;
      cpuClkEn <= resetWake;
      asleep <= !resetWake;
    end else if ((state_q == ST_HOLD) && (resetWake || (cnt_q <= MIN_STARTUP_CYC))) begin
      cpuClkEn <= 1'b1; // see (R5)
      asleep <= 1'b0;
    end
  end

  // conversion start on entry to idle or converter mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      convStart <= 1'b0;
    end else begin
      convStart <= enterSleep && convEnabled &&
                   ((selMode == MODE_IDLE) || (selMode == MODE_CONV_NR)); // see (R12)
    end
  end

  // async timer contents lost after power-save without its own clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      asyncTimerUndef <= 1'b0;
    end else if ((state_q == ST_SLEEP) && wk.wake && !resetWake &&
                 (mode_q == MODE_PWR_SAVE) && !timer2AsyncSel) begin
      asyncTimerUndef <= 1'b1; // see (R24)
    end else if (enterSleep) begin
      asyncTimerUndef <= 1'b0;
    end
  end
endmodule // sleep_mode_controller

// [tb/cpu_wake_model.sv]
// behavioural cpu core and wake sources facing the controller
`timescale 1ns/1ns
module cpu_wake_model (
  // clock
  input wire logic clk,
  // towards the controller
  output logic haltInstr,
  output logic [9:0] src
);
  initial begin
    haltInstr = 1'b0;
    src = 10'h000;
  end
  task automatic halt();
    haltInstr <= 1'b1;
    @(posedge clk);
    haltInstr <= 1'b0;
    @(posedge clk);
  endtask
  // level held long enough to pass the pin synchronisers
  task automatic raise(input int i, input int n);
    src[i] <= 1'b1;
    repeat (n) @(posedge clk);
    src[i] <= 1'b0;
    @(posedge clk);
  endtask
endmodule // cpu_wake_model

// [tb/sleep_mode_controller_chk.sv]
// port-level assertions for the sleep-mode controller
`timescale 1ns/1ns
module sleep_mode_controller_chk
  import sleep_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdData,
  // cpu core
  input wire logic haltInstr,
  input wire logic haltNop,
  input wire logic irqResume,
  input wire logic resetVector,
  input wire logic asleep,
  // clock enables
  input wire logic cpuClkEn,
  input wire logic flashClkEn,
  input wire logic ioClkEn,
  input wire logic convClkEn,
  input wire logic asyncClkEn,
  input wire logic mainOscEn,
  // configuration and sources
  input wire logic convEnabled,
  input wire logic convStart,
  input wire logic extCrystalSel,
  input wire logic timer2AsyncSel,
  input wire logic twiAddrMatch,
  input wire logic resetWake
);
  logic [7:0] ctrl_q;
  logic [2:0] mode_q;
  logic [2:0] sel;
  logic go;
  assign sel = {ctrl_q[BIT_SEL_HI], ctrl_q[BIT_SEL_MID], ctrl_q[BIT_SEL_LO]};
  assign go = haltInstr && !asleep && ctrl_q[BIT_ARM];
  always_ff @(posedge clk) begin
    if (sys_rst) ctrl_q <= CTRL_RESET;
    else if (regWr && regAddr == OFS_CTRL) ctrl_q <= regWrData;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) mode_q <= MODE_IDLE;
    else if (haltInstr && !asleep) mode_q <= sel;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence holdSeq;
    (!cpuClkEn && asleep) [*4] ##1 (cpuClkEn && irqResume && !asleep);
  endsequence
  sequence stbySeq;
    (!ioClkEn) [*6] ##1 ioClkEn;
  endsequence
  AST_READ_CTRL: assert property (
    regRd && regAddr == OFS_CTRL |=> regRdData == ctrl_q)
    else $error("control read data wrong");
  AST_NOP_DISARMED: assert property (
    haltInstr && !asleep && !ctrl_q[BIT_ARM] |=> haltNop && !asleep)
    else $error("halt with arm clear not a no-op");
  AST_NOP_RSVD: assert property (
    go && sel[2:1] == 2'b10 |=> haltNop && !asleep)
    else $error("reserved mode entered sleep");
  AST_NOP_NO_XTAL: assert property (
    go && sel[2:1] == 2'b11 && !extCrystalSel |=> haltNop)
    else $error("standby offered without crystal");
  AST_IDLE_GATE: assert property (
    go && sel == MODE_IDLE |=> asleep && !cpuClkEn && !flashClkEn
    && ioClkEn && convClkEn && asyncClkEn && mainOscEn)
    else $error("idle gating wrong");
  AST_CONV_GATE: assert property (
    go && sel == MODE_CONV_NR |=> !ioClkEn && convClkEn && !cpuClkEn)
    else $error("converter mode gating wrong");
  AST_PDOWN_GATE: assert property (
    go && sel == MODE_PWR_DOWN |=> asleep && !mainOscEn && !ioClkEn
    && !convClkEn && !asyncClkEn)
    else $error("power-down gating wrong");
  AST_CONV_START: assert property (
    go && sel[2:1] == 2'b00 && convEnabled |=> convStart)
    else $error("no conversion start");
  AST_NO_CONV_START: assert property (
    !(go && sel[2:1] == 2'b00 && convEnabled) |=> !convStart)
    else $error("conversion start without cause");
  AST_RESET_WAKE: assert property (
    asleep && resetWake |=> resetVector && !asleep && cpuClkEn)
    else $error("reset did not wake");
  AST_HOLD_FOUR: assert property (
    asleep && $rose(flashClkEn) |-> holdSeq)
    else $error("cpu hold not four cycles");
  AST_STBY_SIX: assert property (
    asleep && mode_q == MODE_STANDBY && !ioClkEn && $rose(twiAddrMatch) |=> stbySeq)
    else $error("standby wake not six cycles");
  AST_PSAVE_ASYNC: assert property (
    asleep && !mainOscEn && mode_q == MODE_PWR_SAVE |-> asyncClkEn == timer2AsyncSel)
    else $error("async clock wrong in power-save");
endmodule // sleep_mode_controller_chk
bind sleep_mode_controller sleep_mode_controller_chk u_sleep_mode_controller_chk (.*);

// [tb/sleep_mode_controller_tb_top.sv]
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ns
module sleep_mode_controller_tb_top
  import sleep_pkg::*;
;
  logic clk, sys_rst, regWr, regRd, haltInstr, haltNop, irqResume, resetVector, asleep;
  logic cpuClkEn, flashClkEn, ioClkEn, convClkEn, asyncClkEn, mainOscEn, asyncTimerUndef;
  logic convEnabled, convStart, extCrystalSel, timer2AsyncSel, timer2OvfIe, timer2CmpIe;
  logic globalIe, extIrqLine0, extIrqLine1, extIrqLine2, twiAddrMatch, timer2Ovf, timer2Cmp;
  logic convDone, spmReady, otherIrq, resetWake, rdFlag;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [CNT_W-1:0] startupCycles;
  logic [9:0] src;
  logic [42:0] expQ[$];
  logic [31:0] seed = 32'h000007F1;
  int cyc, errTotal, testsRun;
  sleep_mode_controller u_sleep_mode_controller (.*);
  cpu_wake_model u_cpu_wake_model (.clk(clk), .haltInstr(haltInstr), .src(src));
  assign {resetWake, otherIrq, spmReady, convDone, timer2Cmp, timer2Ovf, twiAddrMatch,
    extIrqLine2, extIrqLine1, extIrqLine0} = src;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [42:0] seen, input logic [42:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("errors %0d checks %0d", errTotal, testsRun);
    if (errTotal == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // results: read data, then {resetVector, irqResume, haltNop}, then cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rdFlag <= regRd;
  end
  always @(negedge clk) begin
    if (rdFlag || haltNop || irqResume || resetVector)
      check({rdFlag ? regRdData : 8'h00, resetVector, irqResume, haltNop, cyc},
        expQ.size() ? expQ.pop_front() : 'x);
  end
  task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [REG_ADDR_W-1:0] a, input logic [7:0] e);
    expQ.push_back({e, 3'h0, cyc + 2});
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask
  // arm, halt, offer an ignored source, then a wake source due after lat cycles
  task automatic nap(input logic [7:0] c, input int ign, input int w, input int lat);
    logic [2:0] m;
    m = {c[7], c[5], c[4]};
    wr(OFS_CTRL, c);
    if (!c[6] || m[2:1] == 2'b10 || (m[2:1] == 2'b11 && !extCrystalSel)) begin
      expQ.push_back({8'h00, 3'h1, cyc + 2});
      u_cpu_wake_model.halt();
      return;
    end
    u_cpu_wake_model.halt();
    repeat (3) @(posedge clk);
    if (ign < 10) u_cpu_wake_model.raise(ign, 3);
    expQ.push_back({8'h00, (w == 9) ? 3'h4 : 3'h2, cyc + lat});
    u_cpu_wake_model.raise(w, 3);
    for (int i = 0; i < 60 && asleep !== 1'b0; i++) @(posedge clk);
    wr(OFS_CTRL, 8'h00);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    stopTest();
  end
  initial begin
    logic [31:0] d;
    sys_rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = OFS_CTRL;
    regWrData = 8'h00;
    convEnabled = 1'b1;
    extCrystalSel = 1'b0;
    startupCycles = 16'h0003;
    timer2AsyncSel = 1'b0;
    timer2OvfIe = 1'b1;
    timer2CmpIe = 1'b1;
    globalIe = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_STATUS, STATUS_RESET);
    for (int i = 0; i < 4; i++) begin
      d = xs();
      wr(OFS_CTRL, d[7:0]);
      rd(OFS_CTRL, d[7:0]);
    end
    wr(OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, STATUS_RESET);
    rd(2'h2, UNMAPPED_READ);
    nap(8'h00, 10, 0, 0);
    nap(8'hC0, 10, 0, 0);
    nap(8'hD0, 10, 0, 0);
    nap(8'hE0, 10, 0, 0);
    // comparator left powered, so idle still wakes on any source
    nap(8'h40, 10, 8, 7);
    convEnabled <= 1'b0;
    nap(8'h50, 8, 6, 7);
    convEnabled <= 1'b1;
    d = xs() % 6 + 2;
    startupCycles <= d[15:0];
    nap(8'h60, 7, 3, d + 6);
    nap(8'h70, 4, 1, d + 8);
    rd(OFS_STATUS, 8'h0E);
    timer2AsyncSel <= 1'b1;
    globalIe <= 1'b0;
    nap(8'h70, 5, 2, d + 8);
    globalIe <= 1'b1;
    nap(8'h70, 10, 5, d + 6);
    rd(OFS_STATUS, 8'h0C);
    extCrystalSel <= 1'b1;
    nap(8'hE0, 6, 3, 12);
    nap(8'hF0, 7, 0, 14);
    nap(8'h60, 10, 9, 2);
    repeat (20) @(posedge clk);
    check({11'h000, expQ.size()}, 43'h0);
    stopTest();
  end
endmodule // sleep_mode_controller_tb_top
